// ==== core/pmupc_bank.v ====
// Pin control bank: three pin registers, debounce, pad drive, Wishbone slave.
// Assumes OTP default bytes are stable during reset; pads are sampled async.
`include "pmupc_defines.vh"

// One pin's input filter: a new level is taken only once the synchronised
// pad has held it for the whole chosen interval.
module pmupc_debounce (
   input wire clk, // 100 MHz clock
   input wire rst_n, // Synchronised active-low reset
   input wire level, // Synchronised pad level
   input wire long_sel, // Long interval chosen
   output wire filtered // Debounced level
);
   reg filt_reg;
   reg [14:0] cnt_reg;
   wire [14:0] last;

   // Interval read every cycle; a change mid-count applies at once
   assign last = long_sel ? `PMUPC_DEB_LONG_LAST : `PMUPC_DEB_SHORT_LAST;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         filt_reg <= 1'b0;
         cnt_reg <= 15'h0000;
      end else if (level == filt_reg) begin
         // A bounce back restarts the whole interval
         cnt_reg <= 15'h0000;
      end else if (cnt_reg == last) begin
         filt_reg <= level;
         cnt_reg <= 15'h0000;
      end else begin
         cnt_reg <= cnt_reg + 15'h0001;
      end
   end
   assign filtered = filt_reg;
endmodule // pmupc_debounce

// One pin's output stage. The source select and open-drain fields exist
// only on a pin built with FULL set.
module pmupc_pin_drive #(
   parameter FULL = 0
) (
   input wire [7:0] ctrl, // Pin control byte
   input wire sleep_state, // Device in sleep state
   input wire led_channel_a, // LED driver output
   output wire pad_out, // Pad output value
   output wire pad_oe, // Pad drive enable
   output wire seq_member // Pin in power-up sequence
);
   wire full;
   wire is_out;
   wire forced_low;
   wire src;
   wire od;

   assign full = FULL != 0;
   assign is_out = ctrl[`PMUPC_B_CFG];
   assign forced_low = sleep_state & ctrl[`PMUPC_B_SLEEP];
   assign src = full & ctrl[`PMUPC_B_SEL] ? led_channel_a :
      ctrl[`PMUPC_B_SET];
   assign od = full & ctrl[`PMUPC_B_ODEN];
   assign pad_out = src & ~forced_low;
   // Open drain only ever pulls low; the high comes from outside
   assign pad_oe = is_out & (~od | ~pad_out);
   assign seq_member = is_out;
endmodule // pmupc_pin_drive

module pmupc_bank (
   input wire clk, // 100 MHz clock
   input wire nrst, // Async active-low reset
   input wire wb_cyc_i, // Wishbone cycle
   input wire wb_stb_i, // Wishbone strobe
   input wire wb_we_i, // Write enable
   input wire [9:0] wb_adr_i, // Byte address
   input wire [3:0] wb_sel_i, // Byte selects
   input wire [31:0] wb_dat_i, // Write data
   output reg [31:0] wb_dat_o, // Read data
   output reg wb_ack_o, // Acknowledge
   output wire wb_err_o, // Unmapped address answer
   input wire [7:0] otp_pin1, // OTP default, pin 1
   input wire [7:0] otp_pin2, // OTP default, pin 2
   input wire [7:0] otp_pin3, // OTP default, pin 3
   input wire sleep_state, // Device in sleep state
   input wire led_channel_a, // LED driver output for pin 3
   input wire [2:0] pad_in, // Pad levels
   output wire [2:0] pad_out, // Pad output values
   output wire [2:0] pad_oe, // Pad drive enables
   output wire pad_pulldown_en, // Pin 3 pulldown enable
   output wire [2:0] seq_member, // Pins in power-up sequence
   output wire [2:0] pin_filtered // Debounced inputs
);
   reg rst_s1_reg;
   reg rst_s2_reg;
   wire rst_n;
   reg [2:0] pad_s1_reg;
   reg [2:0] pad_s2_reg;
   reg [7:0] pin_reg [0:2];
   reg load_reg;
   wire sel1;
   wire sel2;
   wire sel3;
   wire hit;
   wire req;
   wire [7:0] wdata;
   wire wr;
   reg [7:0] rd_next;
   integer i;

   // Release is synchronised; assertion stays asynchronous
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_s1_reg <= 1'b0;
         rst_s2_reg <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_s2_reg <= rst_s1_reg;
      end
   end
   assign rst_n = rst_s2_reg;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pad_s1_reg <= 3'h0;
         pad_s2_reg <= 3'h0;
      end else begin
         pad_s1_reg <= pad_in;
         pad_s2_reg <= pad_s1_reg;
      end
   end

   assign sel1 = wb_adr_i == `PMUPC_ADDR_PIN1;
   assign sel2 = wb_adr_i == `PMUPC_ADDR_PIN2;
   assign sel3 = wb_adr_i == `PMUPC_ADDR_PIN3;
   assign hit = sel1 | sel2 | sel3;
   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wdata = wb_dat_i[7:0];
   assign wr = req & hit & wb_we_i & wb_sel_i[0];
   assign wb_err_o = wb_cyc_i & wb_stb_i & ~hit;

   // OTP defaults
   // Loaded on the first clocked edge after reset release, never async.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         load_reg <= 1'b1;
         for (i = 0; i < 3; i = i + 1)
            pin_reg[i] <= 8'h00;
      end else begin
         load_reg <= 1'b0;
         if (load_reg) begin
            pin_reg[0] <= otp_pin1 & `PMUPC_WMASK_12;
            pin_reg[1] <= otp_pin2 & `PMUPC_WMASK_12;
            pin_reg[2] <= otp_pin3 & `PMUPC_WMASK_3;
         end else if (wr) begin
            if (sel1)
               pin_reg[0] <= wdata & `PMUPC_WMASK_12;
            if (sel2)
               pin_reg[1] <= wdata & `PMUPC_WMASK_12;
            if (sel3)
               pin_reg[2] <= wdata & `PMUPC_WMASK_3;
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : gen_pin
         pmupc_debounce u_deb (
            .clk(clk),
            .rst_n(rst_n),
            .level(pad_s2_reg[g]),
            .long_sel(pin_reg[g][`PMUPC_B_DEB]),
            .filtered(pin_filtered[g])
         );
         // Only the third pin has source select and open drain
         pmupc_pin_drive #(
            .FULL(g == 2)
         ) u_drv (
            .ctrl(pin_reg[g]),
            .sleep_state(sleep_state),
            .led_channel_a(led_channel_a),
            .pad_out(pad_out[g]),
            .pad_oe(pad_oe[g]),
            .seq_member(seq_member[g])
         );
      end
   endgenerate

   assign pad_pulldown_en = pin_reg[2][`PMUPC_B_PDEN];

   always @* begin
      rd_next = 8'h00;
      if (sel1)
         rd_next = pin_reg[0] | {6'h00, pad_s2_reg[0], 1'b0};
      else if (sel2)
         rd_next = pin_reg[1] | {6'h00, pad_s2_reg[1], 1'b0};
      else if (sel3)
         rd_next = pin_reg[2] | {6'h00, pad_s2_reg[2], 1'b0};
   end

   // Registered ack: every mapped access costs one wait state; unmapped err answers at once
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= req & hit;
         if (req & hit & ~wb_we_i)
            wb_dat_o <= {24'h000000, rd_next};
      end
   end
endmodule // pmupc_bank

// ==== core/pmupc_defines.vh ====
// Constants for the pin control bank: offsets, fields, write masks, timing.
// Assumes a 100 MHz clock and a 32-bit classic Wishbone register bus.
// Notes on behaviour
// - Sleep-force bit drives output pin low
// - Reserved bits read zero, ignore writes
// - Debounce bit picks 94 or 156 us
// - Direction bit: clear input, set output
// - Output pins join power-up sequencing
// - Level bit tracks pad continuously
// - Output pin drives its value bit
// - Reset reloads defaults from OTP settings
// - Pin three output source: value or LED
// - Pin three push-pull or open-drain
// - Pin three pulldown enable bit
`ifndef PMUPC_DEFINES_VH
`define PMUPC_DEFINES_VH
// Register indices; byte address is four times the index
`define PMUPC_IDX_PIN1 8'h41
`define PMUPC_IDX_PIN2 8'h42
`define PMUPC_IDX_PIN3 8'h43
`define PMUPC_ADDR_PIN1 10'h104
`define PMUPC_ADDR_PIN2 10'h108
`define PMUPC_ADDR_PIN3 10'h10c
// Field positions
`define PMUPC_B_SLEEP 7
`define PMUPC_B_SEL 6
`define PMUPC_B_ODEN 5
`define PMUPC_B_DEB 4
`define PMUPC_B_PDEN 3
`define PMUPC_B_CFG 2
`define PMUPC_B_LVL 1
`define PMUPC_B_SET 0
// Writable masks
`define PMUPC_WMASK_12 8'h95
`define PMUPC_WMASK_3 8'hfd
// Debounce times in ns and cycle counts at 10 ns
`define PMUPC_DEB_SHORT_NS 94000
`define PMUPC_DEB_LONG_NS 156000
`define PMUPC_CLK_NS 10
`define PMUPC_DEB_SHORT_CYC (`PMUPC_DEB_SHORT_NS / `PMUPC_CLK_NS)
`define PMUPC_DEB_LONG_CYC (`PMUPC_DEB_LONG_NS / `PMUPC_CLK_NS)
// Last counter value of each interval, one below its cycle count
`define PMUPC_DEB_SHORT_LAST 15'h24b7
`define PMUPC_DEB_LONG_LAST 15'h3cef
`endif

// ==== verification/pmupc_pads.sv ====
// External circuit on the three pads of the bank.
// Assumes the bench sets the outside driver; pin three has a pulldown.
module pmupc_pads (
   input wire [2:0] pad_out, // Bank drive values
   input wire [2:0] pad_oe, // Bank drive enables
   input wire [2:0] ext_lvl, // Outside driver level
   input wire [2:0] ext_en, // Outside driver active
   input wire pad_pulldown_en, // Pin three pulldown
   output wire [2:0] pad_in // Resolved pad levels
);
   // A floating pad shows the inverse level, or low on pin three with its pulldown on
   assign pad_in = pad_oe & pad_out | ~pad_oe & (ext_en & ext_lvl |
      ~ext_en & ~ext_lvl & {~pad_pulldown_en, 2'b11});
endmodule // pmupc_pads

// ==== verification/pmupc_bank_sva.sv ====
// Bus and pad checks for the pin bank.
// Sees only the bank's ports.
`include "pmupc_defines.vh"
module pmupc_bank_sva (
   input wire clk, // Bank clock
   input wire nrst, // Active-low reset at the pin
   input wire wb_cyc_i, // Wishbone cycle
   input wire wb_stb_i, // Wishbone strobe
   input wire wb_we_i, // Write enable
   input wire wb_ack_o, // Acknowledge
   input wire wb_err_o, // Unmapped answer
   input wire [9:0] wb_adr_i, // Byte address
   input wire [31:0] wb_dat_o, // Read data
   input wire [2:0] pad_in, // Pad levels
   input wire [2:0] pad_oe, // Pad drive enables
   input wire [2:0] seq_member, // Sequencer members
   input wire [2:0] pin_filtered, // Debounced inputs
   input wire pad_pulldown_en // Pin three pulldown
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   logic [13:0] cnt_reg;
   // Saturates so a long quiet pad never wraps
   always @(posedge clk or negedge nrst)
      if (!nrst) cnt_reg <= 14'h0;
      else if (pad_in[0] != $past(pad_in[0])) cnt_reg <= 14'h0;
      else if (!(&cnt_reg)) cnt_reg <= cnt_reg + 14'h1;
   sequence taken_s;
      wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   endsequence
   sequence wr_s;
      wb_ack_o && wb_we_i;
   endsequence
   ack_once_a: assert property (taken_s |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not a single pulse");
   err_quiet_a: assert property (wb_err_o |-> !wb_ack_o [*2])
      else $error("ack on unmapped");
   ack_map_a: assert property (wb_ack_o |-> $past(wb_cyc_i && !wb_err_o))
      else $error("ack without request");
   rsvd_zero_a: assert property (wb_ack_o && !wb_we_i |->
      (wb_dat_o & (wb_adr_i == `PMUPC_ADDR_PIN3 ? 32'hffffff00 :
      32'hffffff68)) == 32'h0) else $error("reserved bits set");
   drive_dir_a: assert property ((pad_oe & ~seq_member) == 3'h0)
      else $error("input pin driven");
   seq_hold_a: assert property ($changed(seq_member) && $past(nrst, 4)
      |-> wr_s) else $error("sequence set changed alone");
   pull_hold_a: assert property ($changed(pad_pulldown_en) &&
      $past(nrst, 4) |-> wr_s) else $error("pulldown changed alone");
   filt_wait_a: assert property ($changed(pin_filtered[0]) |->
      cnt_reg > 14'h24ae) else $error("filter too quick");
endmodule // pmupc_bank_sva

// ==== verification/pmupc_bank_test.sv ====
// Self-checking bench for the pin bank and its pad partner.
// Assumes read data is valid in the ack cycle.
`include "pmupc_defines.vh"
module pmupc_bank_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, nrst = 0, cyc = 0, we = 0, sleep = 0, led = 0;
   logic pd, ack, err, gerr;
   logic [9:0] adr = 0;
   logic [31:0] dat = 0, dato, r = 32'hc1354490;
   logic [7:0] o1, o2, o3;
   logic [2:0] ext = 0, en = 3'h7, pi, po, oe, sm, pf;
   logic [15:0] q[$], e;
   int miscompares = 0, n_compared = 0;
   always #5 clk = ~clk;
   pmupc_bank uut (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat),
      .wb_dat_o(dato), .wb_ack_o(ack), .wb_err_o(err), .otp_pin1(o1),
      .otp_pin2(o2), .otp_pin3(o3), .sleep_state(sleep),
      .led_channel_a(led), .pad_in(pi), .pad_out(po), .pad_oe(oe),
      .pad_pulldown_en(pd), .seq_member(sm), .pin_filtered(pf));
   pmupc_pads pads (.pad_out(po), .pad_oe(oe), .ext_lvl(ext), .ext_en(en),
      .pad_pulldown_en(pd), .pad_in(pi));
   function logic [31:0] lf(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task chk(input string n, input logic [7:0] s, x);
      n_compared++;
      if (s !== x) begin
         miscompares++;
         $display("wrong value %s exp %h got %h", n, x, s);
      end
   endtask
   task summarize;
      if (miscompares == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task acc(input logic w, input logic [9:0] a, input logic [7:0] d,
      input logic [15:0] x);
      @(posedge clk);
      cyc <= 1;
      we <= w;
      adr <= a;
      dat <= {24'h0, d};
      if (!w) q.push_back(x);
      // No limit of its own: only the watchdog ends a hung wait
      do @(posedge clk); while (!ack && !err);
      gerr = err;
      cyc <= 0;
   endtask
   always @(posedge clk) if (ack && !we) begin
      e = q.pop_front();
      chk("read", dato[7:0] & e[15:8], e[7:0]);
   end
   initial begin
      o1 = r[7:0];
      o2 = r[15:8];
      o3 = r[23:16];
      repeat (16) @(posedge clk);
      nrst <= 1;
      repeat (4) @(posedge clk);
      acc(0, `PMUPC_ADDR_PIN1, 0, {8'hfd, o1 & 8'h95});
      acc(0, `PMUPC_ADDR_PIN2, 0, {8'hfd, o2 & 8'h95});
      acc(0, `PMUPC_ADDR_PIN3, 0, {8'hfd, o3 & 8'hfd});
      for (int i = 0; i < 9; i++) begin
         r = lf(r);
         acc(1, 10'h104 + 10'(4 * (i % 3)), r[7:0], 0);
         acc(0, 10'h104 + 10'(4 * (i % 3)), 0,
            {8'hfd, r[7:0] & (i % 3 == 2 ? 8'hfd : 8'h95)});
      end
      acc(1, `PMUPC_ADDR_PIN1, 8'h85, 0);
      chk("drive", 8'({oe[0], po[0], sm[0]}), 8'h7);
      sleep <= 1;
      @(posedge clk);
      chk("force", 8'({oe[0], po[0]}), 8'h2);
      acc(1, `PMUPC_ADDR_PIN1, 8'h05, 0);
      chk("keep", 8'(po[0]), 8'h1);
      led <= 1;
      acc(1, `PMUPC_ADDR_PIN3, 8'h44, 0);
      chk("led", 8'({oe[2], po[2]}), 8'h3);
      acc(1, `PMUPC_ADDR_PIN3, 8'h25, 0);
      chk("odrain", 8'(oe[2]), 8'h0);
      acc(1, `PMUPC_ADDR_PIN3, 8'h24, 0);
      chk("odlow", 8'({oe[2], po[2]}), 8'h2);
      en[2] <= 0;
      acc(1, `PMUPC_ADDR_PIN3, 8'h08, 0);
      chk("pull", 8'(pd), 8'h1);
      acc(0, `PMUPC_ADDR_PIN3, 0, 16'h0200);
      en[2] <= 1;
      ext[2] <= 1;
      acc(1, `PMUPC_ADDR_PIN3, 8'h00, 0);
      acc(0, `PMUPC_ADDR_PIN3, 0, 16'h0202);
      for (int i = 0; i < 3; i++) begin
         acc(1, `PMUPC_ADDR_PIN1, i == 1 ? 8'h10 : 8'h00, 0);
         ext[0] <= ~ext[0];
         repeat ((i == 1 ? `PMUPC_DEB_LONG_CYC : `PMUPC_DEB_SHORT_CYC) - 100)
            @(posedge clk);
         if (i > 0) chk("early", 8'(pf[0]), 8'({~ext[0]}));
         repeat (200) @(posedge clk);
         chk("late", 8'(pf[0]), 8'(ext[0]));
      end
      acc(1, 10'h000, 8'h5a, 0);
      chk("unmapped", 8'(gerr), 8'h1);
      summarize();
   end
   initial begin
      #600us;
      miscompares++;
      summarize();
   end
endmodule // pmupc_bank_test
bind pmupc_bank pmupc_bank_sva chk_i (.clk(clk), .nrst(nrst),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .wb_adr_i(wb_adr_i),
   .wb_dat_o(wb_dat_o), .pad_in(pad_in), .pad_oe(pad_oe),
   .seq_member(seq_member), .pin_filtered(pin_filtered),
   .pad_pulldown_en(pad_pulldown_en));
